// *** hdl/dtv_pkg.sv ***
// Constants and carrier types for one division's trip voting logic.
// Assumes a single 10 MHz clock and four divisions in the protection set.
//
// Function
// - Compare each sample to setpoint, one decision.
// - Each division runs on its own clock.
// - Trip when two of four divisions trip.
// - Missing input counts as a trip.
// - Own loss or reset drives tripped output.
// - Decisions exchanged only over isolated peer links.
// - Neutron monitor and manual switches force trip.
// - Same comparison, own division's samples only.
// - Tag each received sample with its channel.
// - Setpoints change only under maintenance key.
// - Vote configuration fixed, never changed on-line.
package dtv_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_DIV  = 4;
  localparam int NUM_PEER = 3;
  localparam int NUM_FUNC = 4;
  localparam int FUNC_W   = 2;
  localparam int DIV_W    = 2;
  localparam int VALUE_W  = 12;
  localparam int CNT_W    = 24;
  localparam int VOTE_W   = 3;

  // ---------------------------------------------------------------
  // Fixed logic configuration and reset values
  // ---------------------------------------------------------------
  localparam logic [VOTE_W-1:0]  VOTE_MIN     = 3'h2;
  localparam logic [VALUE_W-1:0] SETPOINT_RST = 12'hC00;
  localparam logic [DIV_W-1:0]   OWN_DIV_RST  = 2'h0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ            = 10_000_000;
  localparam int CYC_PER_US        = CLK_HZ / 1_000_000;
  localparam int SAMPLE_TIMEOUT_US = 50_000;
  localparam int HEARTBEAT_US      = 1_000;
  localparam int PEER_TIMEOUT_US   = 5_000;
  localparam logic [CNT_W-1:0] SAMPLE_TIMEOUT_CYC =
    CNT_W'(SAMPLE_TIMEOUT_US * CYC_PER_US);
  localparam logic [CNT_W-1:0] HEARTBEAT_CYC =
    CNT_W'(HEARTBEAT_US * CYC_PER_US);
  localparam logic [CNT_W-1:0] PEER_TIMEOUT_CYC =
    CNT_W'(PEER_TIMEOUT_US * CYC_PER_US);

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_START = 3'h1,
    MODE_RUN   = 3'h2,
    MODE_MAINT = 3'h4
  } dtv_mode_e;

  typedef struct packed {
    logic               valid;
    logic [DIV_W-1:0]   division;
    logic [FUNC_W-1:0]  func;
    logic [VALUE_W-1:0] value;
  } dtv_sample_s;

  typedef struct packed {
    logic               valid;
    logic [FUNC_W-1:0]  func;
    logic [VALUE_W-1:0] value;
  } dtv_setpt_s;

  typedef struct packed {
    logic [NUM_PEER-1:0][NUM_FUNC-1:0] peerNormal;
    logic [NUM_PEER-1:0]               peerBeat;
    logic                              nmsNormal;
    logic                              manualNormal;
    logic                              maintKey;
  } dtv_pins_s;

  typedef struct packed {
    dtv_mode_e           mode;
    logic [NUM_PEER-1:0] peerStale;
    logic [NUM_FUNC-1:0] sensorFresh;
  } dtv_status_s;

endpackage : dtv_pkg

// *** hdl/dtv_setpoint_cmp.sv ***
// One setpoint comparison channel with a freshness watchdog.
// Assumes tagged samples and setpoint from the same clock domain.
`timescale 1ns/1ps
`default_nettype none

module dtv_setpoint_cmp #(
  parameter logic [dtv_pkg::CNT_W-1:0] SAMPLE_TIMEOUT = dtv_pkg::SAMPLE_TIMEOUT_CYC
) (
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  input  wire logic                        sampleHit,
  input  wire logic [dtv_pkg::VALUE_W-1:0] sampleValue,
  input  wire logic [dtv_pkg::VALUE_W-1:0] setpoint,
  output logic                             tripDecision,
  output logic                             sampleFresh
);

  typedef struct packed {
    logic                      trip;
    logic                      fresh;
    logic [dtv_pkg::CNT_W-1:0] age;
  } dtv_cmp_state_s;

  dtv_cmp_state_s state_reg;
  dtv_cmp_state_s state_next;

  // ---------------------------------------------------------------
  // Compare and watchdog
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (sampleHit) begin
      state_next.age   = '0;
      state_next.fresh = 1'b1;
      state_next.trip  = (sampleValue >= setpoint);
    end else if (state_reg.age >= SAMPLE_TIMEOUT) begin
      state_next.fresh = 1'b0;
      state_next.trip  = 1'b1;
    end else begin
      state_next.age = state_reg.age + dtv_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= '{trip: 1'b1, fresh: 1'b0, age: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign tripDecision = state_reg.trip;
  assign sampleFresh  = state_reg.fresh;

endmodule : dtv_setpoint_cmp

`default_nettype wire

// *** hdl/dtv_trip_division.sv ***
// Trip decision and two-of-four voting for one protection division.
// Assumes peer and switch pins are asynchronous, samples are on clk.
`timescale 1ns/1ps
`default_nettype none

module dtv_trip_division #(
  parameter logic [dtv_pkg::DIV_W-1:0] OWN_DIV        = dtv_pkg::OWN_DIV_RST,
  parameter logic [dtv_pkg::CNT_W-1:0] SAMPLE_TIMEOUT = dtv_pkg::SAMPLE_TIMEOUT_CYC,
  parameter logic [dtv_pkg::CNT_W-1:0] HEARTBEAT      = dtv_pkg::HEARTBEAT_CYC,
  parameter logic [dtv_pkg::CNT_W-1:0] PEER_TIMEOUT   = dtv_pkg::PEER_TIMEOUT_CYC
) (
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  input  wire dtv_pkg::dtv_sample_s         sampleIn,
  input  wire dtv_pkg::dtv_setpt_s          setptIn,
  input  wire dtv_pkg::dtv_pins_s           pinsIn,
  output logic [dtv_pkg::NUM_FUNC-1:0]      ownNormal,
  output logic                              ownBeat,
  output logic [dtv_pkg::NUM_FUNC-1:0]      tripNormal,
  output dtv_pkg::dtv_status_s              status
);

  localparam int NF = dtv_pkg::NUM_FUNC;
  localparam int NP = dtv_pkg::NUM_PEER;

  typedef struct packed {
    dtv_pkg::dtv_pins_s                        s1;
    dtv_pkg::dtv_pins_s                        s2;
    dtv_pkg::dtv_pins_s                        s3;
    dtv_pkg::dtv_pins_s                        filt;
    logic [NP-1:0]                             beatPrev;
    logic [NP-1:0][dtv_pkg::CNT_W-1:0]         peerAge;
    logic [NP-1:0]                             peerStale;
    logic [dtv_pkg::CNT_W-1:0]                 beatCnt;
    logic                                      ownBeat;
    logic [NF-1:0][dtv_pkg::VALUE_W-1:0]       setpoint;
    dtv_pkg::dtv_mode_e                        mode;
    logic                                      tagValid;
    logic [dtv_pkg::FUNC_W-1:0]                tagFunc;
    logic [dtv_pkg::VALUE_W-1:0]               tagValue;
    logic [NF-1:0]                             ownNormal;
    logic [NF-1:0]                             tripNormal;
  } dtv_top_state_s;

  dtv_top_state_s state_reg;
  dtv_top_state_s state_next;

  logic [NF-1:0] cmpTrip;
  logic [NF-1:0] cmpFresh;

  // ---------------------------------------------------------------
  // Setpoint comparison channels
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NF; g++) begin : gen_cmp
      dtv_setpoint_cmp #(
        .SAMPLE_TIMEOUT (SAMPLE_TIMEOUT)
      ) u_cmp (
        .clk          (clk),
        .arst_n       (arst_n),
        .sampleHit    (state_reg.tagValid &&
                       (state_reg.tagFunc == dtv_pkg::FUNC_W'(g))),
        .sampleValue  (state_reg.tagValue),
        .setpoint     (state_reg.setpoint[g]),
        .tripDecision (cmpTrip[g]),
        .sampleFresh  (cmpFresh[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [dtv_pkg::VOTE_W-1:0] voteCnt;
    logic                       forceTrip;
    voteCnt    = '0;
    forceTrip  = 1'b0;
    state_next = state_reg;

    state_next.s1 = pinsIn;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    state_next.filt = (state_reg.filt & ~(state_reg.s2 ^ state_reg.s3)) |
                      (state_reg.s3 & ~(state_reg.s2 ^ state_reg.s3));

    state_next.beatPrev = state_reg.filt.peerBeat;
    for (int p = 0; p < NP; p++) begin
      if (state_reg.filt.peerBeat[p] != state_reg.beatPrev[p]) begin
        state_next.peerAge[p]   = '0;
        state_next.peerStale[p] = 1'b0;
      end else if (state_reg.peerAge[p] >= PEER_TIMEOUT) begin
        state_next.peerStale[p] = 1'b1;
      end else begin
        state_next.peerAge[p] = state_reg.peerAge[p] + dtv_pkg::CNT_W'(1);
      end
    end

    if (state_reg.beatCnt >= HEARTBEAT - dtv_pkg::CNT_W'(1)) begin
      state_next.beatCnt = '0;
      state_next.ownBeat = ~state_reg.ownBeat;
    end else begin
      state_next.beatCnt = state_reg.beatCnt + dtv_pkg::CNT_W'(1);
    end

    state_next.tagValid = sampleIn.valid && (sampleIn.division == OWN_DIV);
    state_next.tagFunc  = sampleIn.func;
    state_next.tagValue = sampleIn.value;

    case (state_reg.mode)
      dtv_pkg::MODE_START: begin
        if (state_reg.filt.maintKey) begin
          state_next.mode = dtv_pkg::MODE_MAINT;
        end else if (&cmpFresh) begin
          state_next.mode = dtv_pkg::MODE_RUN;
        end
      end
      dtv_pkg::MODE_RUN: begin
        if (state_reg.filt.maintKey) begin
          state_next.mode = dtv_pkg::MODE_MAINT;
        end
      end
      dtv_pkg::MODE_MAINT: begin
        if (!state_reg.filt.maintKey) begin
          state_next.mode = dtv_pkg::MODE_START;
        end
      end
      default: begin
        state_next.mode = dtv_pkg::MODE_START;
      end
    endcase

    if (setptIn.valid && (state_reg.mode == dtv_pkg::MODE_MAINT)) begin
      state_next.setpoint[setptIn.func] = setptIn.value;
    end

    state_next.ownNormal = (state_reg.mode == dtv_pkg::MODE_RUN) ? ~cmpTrip : '0;

    forceTrip = !state_reg.filt.nmsNormal || !state_reg.filt.manualNormal ||
                (state_reg.mode != dtv_pkg::MODE_RUN);

    for (int i = 0; i < NF; i++) begin
      voteCnt = dtv_pkg::VOTE_W'(cmpTrip[i]);
      for (int p = 0; p < NP; p++) begin
        voteCnt = voteCnt + dtv_pkg::VOTE_W'(!state_reg.filt.peerNormal[p][i] ||
                                             state_reg.peerStale[p]);
      end
      state_next.tripNormal[i] = !((voteCnt >= dtv_pkg::VOTE_MIN) || forceTrip);
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Reset de-energises outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg.s1         <= '0;
      state_reg.s2         <= '0;
      state_reg.s3         <= '0;
      state_reg.filt       <= '0;
      state_reg.beatPrev   <= '0;
      state_reg.peerAge    <= '0;
      state_reg.peerStale  <= '1;
      state_reg.beatCnt    <= '0;
      state_reg.ownBeat    <= 1'b0;
      state_reg.setpoint   <= {NF{dtv_pkg::SETPOINT_RST}};
      state_reg.mode       <= dtv_pkg::MODE_START;
      state_reg.tagValid   <= 1'b0;
      state_reg.tagFunc    <= '0;
      state_reg.tagValue   <= '0;
      state_reg.ownNormal  <= '0;
      state_reg.tripNormal <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign ownNormal          = state_reg.ownNormal;
  assign ownBeat            = state_reg.ownBeat;
  assign tripNormal         = state_reg.tripNormal;
  assign status             = '{mode:        state_reg.mode,
                                peerStale:   state_reg.peerStale,
                                sensorFresh: cmpFresh};

endmodule : dtv_trip_division

`default_nettype wire

// *** sim/dtv_peer_model.sv ***
// Three peer divisions seen over the isolated links.
// Assumes the bench sets each peer's trip bits and silence.
`timescale 1ns/1ps
`default_nettype none
module dtv_peer_model #(
  parameter int BEAT = 8
) (
  input  wire logic        clk,
  input  wire logic [11:0] peerTrip,
  input  wire logic [2:0]  silent,
  output var logic  [11:0] peerNormal,
  output var logic  [2:0]  peerBeat
);
  int age [3] = '{0, 0, 0};
  initial peerBeat = 3'h0;
  initial peerNormal = 12'hFFF;
  always @(posedge clk) begin
    for (int p = 0; p < 3; p++) begin
      age[p] <= (age[p] >= BEAT + p) ? 0 : age[p] + 1;
      if (!silent[p] && age[p] >= BEAT + p) peerBeat[p] <= ~peerBeat[p];
      peerNormal[p*4+:4] <= silent[p] ? ~peerNormal[p*4+:4] : ~peerTrip[p*4+:4];
    end
  end
endmodule : dtv_peer_model
`default_nettype wire

// *** sim/dtv_trip_checker.sv ***
// Port checker for one division's trip voting logic.
// Assumes binding to every dtv_trip_division instance.
`timescale 1ns/1ps
`default_nettype none
module dtv_trip_checker #(
  parameter logic [1:0]  OWN_DIV   = 2'h0,
  parameter logic [23:0] HEARTBEAT = 24'h8
) (
  input wire logic                 clk,
  input wire logic                 arst_n,
  input wire dtv_pkg::dtv_sample_s sampleIn,
  input wire dtv_pkg::dtv_setpt_s  setptIn,
  input wire dtv_pkg::dtv_pins_s   pinsIn,
  input wire logic [3:0]           ownNormal,
  input wire logic                 ownBeat,
  input wire logic [3:0]           tripNormal,
  input wire dtv_pkg::dtv_status_s status
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  logic ownHit;
  assign ownHit = sampleIn.valid && sampleIn.division == OWN_DIV;
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  reset_hold_a: assert property ($rose(arst_n) |-> !tripNormal && &status.peerStale)
    else $error("outputs left reset state");
  notrun_trip_a: assert property ((status.mode != dtv_pkg::MODE_RUN) [*2] |->
    tripNormal == 4'h0 && ownNormal == 4'h0) else $error("output normal outside run");
  nms_trip_a: assert property ((!pinsIn.nmsNormal) [*7] |-> tripNormal == 4'h0)
    else $error("neutron trip not voted");
  sample_trip_a: assert property (ownHit && sampleIn.value == 12'hFFF |->
    ##3 !ownNormal[$past(sampleIn.func, 3)]) else $error("high sample did not trip");
  fresh_mark_a: assert property (ownHit |-> ##2 status.sensorFresh[$past(sampleIn.func, 2)])
    else $error("sample not marked fresh");
  stale_vote_a: assert property ((&status.peerStale) [*2] |-> tripNormal == 4'h0)
    else $error("stale peers did not trip");
  beat_period_a: assert property ($changed(ownBeat) |=> $stable(ownBeat) [*7]
    ##1 $changed(ownBeat)) else $error("heartbeat period wrong");
  maint_mode_a: assert property (pinsIn.maintKey [*7] |->
    status.mode == dtv_pkg::MODE_MAINT) else $error("key did not enter maintenance");
  run_cv: cover property (status.mode == dtv_pkg::MODE_RUN && tripNormal != 4'hF);
  stale_cv: cover property (status.peerStale == 3'h4);
  maint_cv: cover property (setptIn.valid && status.mode == dtv_pkg::MODE_MAINT);
endmodule : dtv_trip_checker

bind dtv_trip_division dtv_trip_checker #(.OWN_DIV(OWN_DIV), .HEARTBEAT(HEARTBEAT)) u_chk (
  .clk(clk), .arst_n(arst_n), .sampleIn(sampleIn), .setptIn(setptIn), .pinsIn(pinsIn),
  .ownNormal(ownNormal), .ownBeat(ownBeat), .tripNormal(tripNormal), .status(status));
`default_nettype wire

// *** sim/tb.sv ***
// Bench: samples, setpoints and pins into one division.
// Assumes the peer model on the links and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {int due; logic [3:0] own; logic [3:0] trip;} dtv_note_s;
  logic                 clk = 1'b0;
  logic                 arst_n = 1'b0;
  dtv_pkg::dtv_sample_s smp = '0;
  dtv_pkg::dtv_setpt_s  spt = '0;
  logic [11:0]          pTrip = '0;
  logic [2:0]           silent = '0;
  logic                 neutron_monitor_inputs = 1'b1;
  logic                 man = 1'b1;
  logic                 key = 1'b0;
  logic [11:0]          pNorm;
  logic [2:0]           pBeat;
  logic [3:0]           ownN;
  logic [3:0]           tripN;
  logic                 beat;
  logic                 b0;
  dtv_pkg::dtv_status_s st;
  logic [3:0]           oTrip = '0;
  logic [11:0]          spv [4] = '{4{dtv_pkg::SETPOINT_RST}};
  int                   miscompares = 0;
  int                   tests_run = 0;
  int                   cyc = 0;
  dtv_note_s            notes [$];
  always #50 clk = ~clk;
  always @(posedge clk) cyc++;
  dtv_peer_model peer (.clk(clk), .peerTrip(pTrip), .silent(silent),
    .peerNormal(pNorm), .peerBeat(pBeat));
  dtv_trip_division #(.SAMPLE_TIMEOUT(24'h3E8), .HEARTBEAT(24'h8), .PEER_TIMEOUT(24'h1E)) dut (
    .clk(clk), .arst_n(arst_n), .sampleIn(smp), .setptIn(spt),
    .pinsIn({pNorm, pBeat, neutron_monitor_inputs, man, key}), .ownNormal(ownN), .ownBeat(beat),
    .tripNormal(tripN), .status(st));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic send(logic [1:0] d, int f, logic [11:0] v);
    @(negedge clk);
    smp <= '{1'b1, d, 2'(f), v};
    if (d == 2'h0) oTrip[f] = v >= spv[f];
    @(negedge clk);
    smp.valid <= 1'b0;
  endtask : send
  task automatic refresh;
    for (int f = 0; f < 4; f++) send(2'h0, f, oTrip[f] ? 12'hFFF : 12'h000);
  endtask : refresh
  task automatic wrsp(int f, logic [11:0] v);
    @(negedge clk);
    spt <= '{1'b1, 2'(f), v};
    if (key) spv[f] = v;
    @(negedge clk);
    spt.valid <= 1'b0;
  endtask : wrsp
  task automatic note(int dly);
    logic [3:0] t;
    int         v;
    for (int f = 0; f < 4; f++) begin
      v = oTrip[f];
      for (int p = 0; p < 3; p++) v += pTrip[p*4+f] | silent[p];
      t[f] = v >= 2 || !neutron_monitor_inputs || !man;
    end
    notes.push_back('{cyc + dly, ~oTrip, ~t});
    repeat (dly + 1) @(negedge clk);
  endtask : note
  task automatic results;
    $display("counts: %0d compares, %0d bad", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  // ------------------------------------------------------------
  // Monitor, watchdog and tests
  // ------------------------------------------------------------
  always @(negedge clk) begin
    if (notes.size() > 0 && cyc >= notes[0].due) begin
      chk("ownNormal", notes[0].own, ownN);
      chk("tripNormal", notes[0].trip, tripN);
      void'(notes.pop_front());
    end
  end
  initial begin
    #500_000;
    miscompares++;
    results();
  end
  initial begin
    void'($urandom(11810));
    repeat (6) @(negedge clk);
    chk("rstOut", 8'h00, {tripN, ownN});
    chk("rstMode", 8'h01, 8'(st.mode));
    arst_n = 1'b1;
    refresh();
    note(30);
    chk("run", 8'h02, 8'(st.mode));
    b0 = beat;
    repeat (8) @(negedge clk);
    chk("beat", {7'h00, !b0}, {7'h00, beat});
    $display("end start");
    for (int i = 0; i < 20; i++) begin
      pTrip = 12'($urandom);
      for (int f = 0; f < 4; f++)
        send(2'($urandom_range(3)), f, 12'hBFE + 12'($urandom_range(3)));
      note(12);
    end
    pTrip = '0;
    $display("end vote");
    for (int k = 0; k < 2; k++) begin
      {neutron_monitor_inputs, man} = 2'(k + 1);
      note(10);
      {neutron_monitor_inputs, man} = 2'h3;
      note(10);
    end
    $display("end pins");
    refresh();
    send(2'h0, 3, 12'hFFF);
    silent = 3'h4;
    note(60);
    chk("stale", 8'h04, 8'(st.peerStale));
    silent = 3'h0;
    note(40);
    $display("end stale");
    oTrip = 4'h0;
    refresh();
    wrsp(0, 12'h100);
    send(2'h0, 0, 12'h200);
    note(10);
    key = 1'b1;
    repeat (10) @(negedge clk);
    chk("maint", 8'h04, {tripN, 1'b0, st.mode});
    wrsp(0, 12'h100);
    key = 1'b0;
    repeat (10) @(negedge clk);
    refresh();
    send(2'h0, 0, 12'h200);
    note(10);
    $display("end maint");
    repeat (1010) @(negedge clk);
    oTrip = 4'hF;
    note(2);
    chk("fresh", 8'h00, 8'(st.sensorFresh));
    refresh();
    note(10);
    $display("end timeout");
    arst_n = 1'b0;
    #1;
    chk("midRst", 8'h00, {tripN, ownN});
    chk("midBeat", 8'h00, {7'h00, beat});
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    spv = '{4{dtv_pkg::SETPOINT_RST}};
    repeat (2) @(negedge clk);
    chk("relOut", 8'h00, {tripN, ownN});
    chk("relMode", 8'h01, 8'(st.mode));
    refresh();
    note(30);
    $display("end reset");
    results();
  end
endmodule : tb
`default_nettype wire
